// ---- rtl/bt_path.sv ----
// One direction of storage: transparent latch plus enabled flip-flop
`timescale 1ns/1ps
module bt_path (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Direction signals
    bt_path_if.path   p
);
    typedef struct packed {
        logic [bt_pkg::WIDTH-1:0] held;
        logic                     clk_prev;
        logic                     le_prev;
        logic                     cap;
    } bt_path_s;

    bt_path_s s_q;
    bt_path_s s_d;
    logic     clk_rise;
    logic     le_fall;

    // Edge detection on the already filtered controls
    assign clk_rise = p.clk_lvl & ~s_q.clk_prev;
    assign le_fall  = s_q.le_prev & ~p.latch_open;

    // Next state of the storage element
    always_comb begin
        s_d          = s_q;
        s_d.clk_prev = p.clk_lvl;
        s_d.le_prev  = p.latch_open;
        s_d.cap      = 1'b0;
        if (p.latch_open) begin
            s_d.held = p.din;          // Follow input
        end else if (p.clk_enable_n) begin
            s_d.held = s_q.held;       // Edges ignored
        end else if (le_fall) begin
            s_d.held = p.din;          // Close on latch fall
        end else if (clk_rise) begin
            s_d.held = p.din;          // Edge capture
            s_d.cap  = 1'b1;
        end else begin
            s_d.held = s_q.held;       // Static clock holds
        end
    end

    // Storage has no reset, only the edge trackers and the capture flag do
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q.clk_prev <= 1'b0;
            s_q.le_prev  <= 1'b0;
            s_q.cap      <= 1'b0;
            s_q.held     <= s_d.held;
        end else begin
            s_q <= s_d;
        end
    end

    // Output without inversion
    assign p.dout    = s_q.held;
    assign p.capture = s_q.cap;
endmodule

// ---- rtl/bt_path_if.sv ----
// Signals between the top level and one direction's data path
`timescale 1ns/1ps
interface bt_path_if;
    logic [bt_pkg::WIDTH-1:0] din;
    logic                     clk_lvl;
    logic                     latch_open;
    logic                     clk_enable_n;
    logic [bt_pkg::WIDTH-1:0] dout;
    logic                     capture;

    // Path side
    modport path (
        input  din,
        input  clk_lvl,
        input  latch_open,
        input  clk_enable_n,
        output dout,
        output capture
    );
    // Owner side
    modport owner (
        output din,
        output clk_lvl,
        output latch_open,
        output clk_enable_n,
        input  dout,
        input  capture
    );
endinterface

// ---- rtl/bt_pkg.sv ----
// Shared constants for the bidirectional latch and flop transceiver
package bt_pkg;
    // Data path width per direction
    localparam int WIDTH     = 17;
    // Buffer of capture events: one direction bit plus data
    localparam int ENT_W     = WIDTH + 1;
    localparam int BUF_DEPTH = 2;
    // Bit positions inside the synchronised pin vector
    localparam int SY_CARD   = 0;
    localparam int SY_BP     = 17;
    localparam int SY_FCLK   = 34;
    localparam int SY_RCLK   = 35;
    localparam int SY_FLE    = 36;
    localparam int SY_RLE    = 37;
    localparam int SY_FCE    = 38;
    localparam int SY_RCE    = 39;
    localparam int SY_FOE    = 40;
    localparam int SY_ROE    = 41;
    localparam int SY_BPCLK  = 42;
    localparam int SY_W      = 43;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_FWD_HELD = 8'h08;
    localparam logic [7:0] OFF_REV_HELD = 8'h0C;
    localparam logic [7:0] OFF_LOG      = 8'h10;
    localparam logic [7:0] OFF_LOG_STAT = 8'h14;
    localparam logic [7:0] OFF_NONE     = 8'hFF;
    // Field positions
    localparam int CTRL_ARM   = 0;
    localparam int CTRL_GUARD = 1;
    localparam int LSTAT_OVF  = 0;
    localparam int LOG_VALID  = 31;
    // Reset values
    localparam logic CTRL_ARM_RST   = 1'b0;
    localparam logic CTRL_GUARD_RST = 1'b0;
endpackage

// ---- rtl/bt_transceiver.sv ----
// Top level of the 17-bit bidirectional latch and flop transceiver
// What this block does
// - Data passes without inversion in every mode and direction.
// - Each direction is 17 bits; one clock enable gates all of them.
// - Enable low, latch closed: rising data clock captures card data.
// - Enable low: falling latch enable holds the data present then.
// - Enable and latch low: data stays held whatever static clock level.
// - Latch enable high: outputs follow inputs, ignoring clock and enable.
// - Entering storage with clock high keeps the earlier output level.
// - Clock enable high, latch closed: clock edges ignored, data kept.
// - Low forward drive enable drives backplane data outputs unless the guard bit is set and reverse enable is also low.
// - High forward drive enable isolates backplane data outputs.
// - Reverse direction mirrors forward with its own four controls, except that the guard bit also gates its clock return.
// - Drive enables also gate the two buffered clock paths.
// - Forward enable low drives delayed clock copy onto backplane line.
// - Reverse enable low returns the backplane clock to the card unless the guard bit is set and forward enable is also low.
// - All outputs stay high impedance through power-up and power-down.
//
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module bt_transceiver (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Card side data pins
    input  wire logic [bt_pkg::WIDTH-1:0]  card_data_in,
    output logic      [bt_pkg::WIDTH-1:0]  card_data_out,
    output logic                           card_data_oe,
    // Backplane side data pins
    input  wire logic [bt_pkg::WIDTH-1:0]  bp_data_in,
    output logic      [bt_pkg::WIDTH-1:0]  bp_data_out,
    output logic                           bp_data_oe,
    // Buffered clock path
    input  wire logic                      fwd_data_clock,
    input  wire logic                      rev_data_clock,
    input  wire logic                      backplane_clock_line_in,
    output logic                           backplane_clock_line_out,
    output logic                           backplane_clock_line_oe,
    output logic                           card_clock_return_out,
    output logic                           card_clock_return_oe,
    // Direction controls
    input  wire logic                      fwd_clk_enable_n,
    input  wire logic                      rev_clk_enable_n,
    input  wire logic                      fwd_latch_open,
    input  wire logic                      rev_latch_open,
    input  wire logic                      fwd_drive_enable_n,
    input  wire logic                      rev_drive_enable_n,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic [31:0]                    hrdata,
    output logic                           hresp
);
    localparam int SW = bt_pkg::SY_W;
    localparam int EW = bt_pkg::ENT_W;
    localparam int DW = bt_pkg::WIDTH;

    typedef struct packed {
        logic [SW-1:0]                    s1;
        logic [SW-1:0]                    s2;
        logic [SW-1:0]                    s3;
        logic [SW-1:0]                    filt;
        logic                             arm;
        logic                             guard;
        logic [bt_pkg::BUF_DEPTH-1:0][EW-1:0] mem;
        logic                             wp;
        logic                             rp;
        logic [1:0]                       cnt;
        logic                             ovf;
        logic                             ph_valid;
        logic                             ph_write;
        logic [7:0]                       ph_addr;
        logic [31:0]                      rdata;
        logic                             clk_copy;
    } bt_top_s;

    bt_top_s         s_q;
    bt_top_s         s_d;
    logic [SW-1:0]   pins;
    logic [SW-1:0]   agree;
    logic            both_on;
    logic            fwd_on;
    logic            rev_on;
    logic            fwd_clk_on;
    logic            rev_clk_on;
    logic            push_valid;
    logic            push_ready;
    logic [EW-1:0]   push_data;
    logic            lost;
    logic            pop_valid;
    logic            pop_ready;
    logic            acc;
    logic [7:0]      sel_addr;

    bt_path_if fwd_if ();
    bt_path_if rev_if ();

    // Gather every pin input into one vector for synchronising
    assign pins = {backplane_clock_line_in,
                   rev_drive_enable_n, fwd_drive_enable_n,
                   rev_clk_enable_n, fwd_clk_enable_n,
                   rev_latch_open, fwd_latch_open,
                   rev_data_clock, fwd_data_clock,
                   bp_data_in, card_data_in};

    // A change counts once the second and third stages agree
    assign agree = ~(s_q.s2 ^ s_q.s3);

    // Forward path: card to backplane
    assign fwd_if.din          = s_q.filt[bt_pkg::SY_CARD +: DW];
    assign fwd_if.clk_lvl      = s_q.filt[bt_pkg::SY_FCLK];
    assign fwd_if.latch_open   = s_q.filt[bt_pkg::SY_FLE];
    assign fwd_if.clk_enable_n = s_q.filt[bt_pkg::SY_FCE];

    // Reverse path mirrors forward with its own controls
    assign rev_if.din          = s_q.filt[bt_pkg::SY_BP +: DW];
    assign rev_if.clk_lvl      = s_q.filt[bt_pkg::SY_RCLK];
    assign rev_if.latch_open   = s_q.filt[bt_pkg::SY_RLE];
    assign rev_if.clk_enable_n = s_q.filt[bt_pkg::SY_RCE];

    bt_path u_fwd (
        .clk   (clk),
        .reset (reset),
        .p     (fwd_if)
    );

    bt_path u_rev (
        .clk   (clk),
        .reset (reset),
        .p     (rev_if)
    );

    // Drive enables; both outputs stay off until software arms them
    assign both_on = ~s_q.filt[bt_pkg::SY_FOE] & ~s_q.filt[bt_pkg::SY_ROE];
    assign fwd_clk_on = ~reset & s_q.arm
                      & ~s_q.filt[bt_pkg::SY_FOE];
    assign rev_clk_on = ~reset & s_q.arm & ~s_q.filt[bt_pkg::SY_ROE]
                      & ~(s_q.guard & both_on);
    assign fwd_on = fwd_clk_on & ~(s_q.guard & both_on);
    assign rev_on = rev_clk_on;

    // Data pins: low enable drives, high enable isolates
    assign bp_data_out   = fwd_if.dout;
    assign bp_data_oe    = fwd_on;
    assign card_data_out = rev_if.dout;
    assign card_data_oe  = rev_on;

    // Clock path outputs
    assign backplane_clock_line_out = s_q.clk_copy;
    assign backplane_clock_line_oe  = fwd_clk_on;
    assign card_clock_return_out    = s_q.filt[bt_pkg::SY_BPCLK];
    assign card_clock_return_oe     = rev_clk_on;

    // Capture log: forward capture wins when both directions fire
    assign push_valid = fwd_if.capture | rev_if.capture;
    assign push_data  = fwd_if.capture ? {1'b0, fwd_if.dout}
                                       : {1'b1, rev_if.dout};
    assign push_ready = (s_q.cnt != 2'h2);
    assign lost       = (fwd_if.capture & rev_if.capture)
                      | (push_valid & ~push_ready);
    assign pop_valid  = (s_q.cnt != 2'h0);

    // Bus address phase acceptance and decode
    assign acc       = hsel & hready & htrans[1];
    assign sel_addr  = (haddr[31:8] == 24'h000000) ? haddr[7:0]
                                                   : bt_pkg::OFF_NONE;
    assign pop_ready = acc & ~hwrite & (sel_addr == bt_pkg::OFF_LOG);

    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_q.rdata;

    // Next state of synchronisers, buffer and registers
    always_comb begin
        s_d          = s_q;
        s_d.s1       = pins;
        s_d.s2       = s_q.s1;
        s_d.s3       = s_q.s2;
        s_d.filt     = (s_q.filt & ~agree) | (s_q.s3 & agree);
        s_d.clk_copy = s_q.filt[bt_pkg::SY_FCLK];  // Delayed copy, no inversion

        // Buffer push and pop
        if (push_valid & push_ready) begin
            s_d.mem[s_q.wp] = push_data;
            s_d.wp          = ~s_q.wp;
        end
        if (pop_valid & pop_ready) begin
            s_d.rp = ~s_q.rp;
        end
        s_d.cnt = 2'(s_q.cnt + {1'b0, push_valid & push_ready}
                             - {1'b0, pop_valid & pop_ready});

        // Address phase capture
        s_d.ph_valid = acc;
        s_d.ph_write = hwrite;
        s_d.ph_addr  = sel_addr;

        // Read data is prepared at the address phase
        s_d.rdata = 32'h00000000;
        if (acc & ~hwrite) begin
            case (sel_addr)
                bt_pkg::OFF_CTRL: begin
                    s_d.rdata = {30'h00000000, s_q.guard, s_q.arm};
                end
                bt_pkg::OFF_STATUS: begin
                    s_d.rdata = {23'h000000,
                        s_q.filt[bt_pkg::SY_BPCLK:bt_pkg::SY_FCLK]};
                end
                bt_pkg::OFF_FWD_HELD: begin
                    s_d.rdata = {15'h0000, fwd_if.dout};
                end
                bt_pkg::OFF_REV_HELD: begin
                    s_d.rdata = {15'h0000, rev_if.dout};
                end
                bt_pkg::OFF_LOG: begin
                    if (pop_valid) begin
                        s_d.rdata = {1'b1, 13'h0000, s_q.mem[s_q.rp]};
                    end
                end
                bt_pkg::OFF_LOG_STAT: begin
                    s_d.rdata = {29'h00000000, s_q.cnt, s_q.ovf};
                end
                default: begin
                    s_d.rdata = 32'h00000000;
                end
            endcase
        end

        // Writes land in the data phase
        if (s_q.ph_valid & s_q.ph_write) begin
            case (s_q.ph_addr)
                bt_pkg::OFF_CTRL: begin
                    s_d.arm   = hwdata[bt_pkg::CTRL_ARM];
                    s_d.guard = hwdata[bt_pkg::CTRL_GUARD];
                end
                bt_pkg::OFF_LOG_STAT: begin
                    if (hwdata[bt_pkg::LSTAT_OVF]) begin
                        s_d.ovf = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // A lost capture sets the flag after any clear, so it wins
        if (lost) begin
            s_d.ovf = 1'b1;
        end
    end

    // Register the whole state; outputs come up isolated
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q       <= '0;
            s_q.arm   <= bt_pkg::CTRL_ARM_RST;
            s_q.guard <= bt_pkg::CTRL_GUARD_RST;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ---- test/bt_bp_model.sv ----
// Backplane model: terminated wires and a remote card driving them
`timescale 1ns/1ps
module bt_bp_model (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset,
    // Device side
    input  wire logic [bt_pkg::WIDTH-1:0] dev_data,
    input  wire logic                     dev_data_oe,
    input  wire logic                     dev_clk,
    input  wire logic                     dev_clk_oe,
    // Remote card control
    input  wire logic                     drv_en,
    input  wire logic [bt_pkg::WIDTH-1:0] drv_data,
    // Resolved wires
    output logic      [bt_pkg::WIDTH-1:0] bp_wire,
    output logic                          clk_wire
);
    logic [2:0] cnt_q;
    logic       rclk_q;

    // Remote clock idles high, half period of five cycles while driving
    always_ff @(posedge clk) begin
        if (reset || !drv_en) begin
            cnt_q  <= 3'h0;
            rclk_q <= 1'h1;
        end else if (cnt_q == 3'h4) begin
            cnt_q  <= 3'h0;
            rclk_q <= !rclk_q;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // Undriven wires sit at the termination level
    assign bp_wire  = dev_data_oe ? dev_data : (drv_en ? drv_data : '1);
    assign clk_wire = dev_clk_oe ? dev_clk : (drv_en ? rclk_q : 1'h1);
endmodule

// ---- test/bt_checker.sv ----
// Concurrent checks on the transceiver top-level ports
`timescale 1ns/1ps
module bt_checker (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     reset,
    // Data pins
    input wire logic [bt_pkg::WIDTH-1:0] card_data_in,
    input wire logic [bt_pkg::WIDTH-1:0] card_data_out,
    input wire logic                     card_data_oe,
    input wire logic [bt_pkg::WIDTH-1:0] bp_data_in,
    input wire logic [bt_pkg::WIDTH-1:0] bp_data_out,
    input wire logic                     bp_data_oe,
    // Clock path
    input wire logic                     fwd_data_clock,
    input wire logic                     backplane_clock_line_in,
    input wire logic                     backplane_clock_line_out,
    input wire logic                     backplane_clock_line_oe,
    input wire logic                     card_clock_return_out,
    input wire logic                     card_clock_return_oe,
    // Controls
    input wire logic                     fwd_clk_enable_n,
    input wire logic                     fwd_latch_open,
    input wire logic                     rev_latch_open,
    input wire logic                     fwd_drive_enable_n,
    input wire logic                     rev_drive_enable_n
);
    logic [3:0] up_q, ft_q, rt_q, fh_q;

    // Saturating count, cleared when the condition drops
    function automatic logic [3:0] sat(input logic [3:0] c, input logic k);
        return k ? c + {3'h0, c != 4'hF} : 4'h0;
    endfunction

    // Cycles since reset and cycles each settled condition has held
    always_ff @(posedge clk) begin
        if (reset) begin
            up_q <= 4'h0;
            ft_q <= 4'h0;
            rt_q <= 4'h0;
            fh_q <= 4'h0;
        end else begin
            up_q <= sat(up_q, 1'h1);
            ft_q <= sat(ft_q, fwd_latch_open && $stable(card_data_in));
            rt_q <= sat(rt_q, rev_latch_open && $stable(bp_data_in));
            fh_q <= sat(fh_q, !fwd_latch_open
                && (fwd_clk_enable_n || !$rose(fwd_data_clock)));
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_PWR_OFF: assert property (
        $fell(reset) |-> (!(card_data_oe || bp_data_oe
        || backplane_clock_line_oe || card_clock_return_oe)) [*3])
        else $error("outputs driven right after reset");
    AST_FWD_PASS: assert property (
        ft_q > 4'h8 |-> bp_data_out == card_data_in)
        else $error("forward transparent data differs");
    AST_REV_PASS: assert property (
        rt_q > 4'h8 |-> card_data_out == bp_data_in)
        else $error("reverse transparent data differs");
    AST_FWD_HOLD: assert property (
        fh_q > 4'h8 |-> $stable(bp_data_out))
        else $error("held forward data changed");
    AST_CLK_COPY: assert property (
        backplane_clock_line_oe && up_q > 4'h8
        |-> backplane_clock_line_out == $past(fwd_data_clock, 5))
        else $error("backplane clock copy wrong");
    AST_CLK_RET: assert property (
        card_clock_return_oe && up_q > 4'h8
        |-> card_clock_return_out == $past(backplane_clock_line_in, 4))
        else $error("card clock return wrong");
    AST_FWD_OFF: assert property (
        up_q > 4'h8 && $past(fwd_drive_enable_n, 4)
        |-> !bp_data_oe && !backplane_clock_line_oe)
        else $error("forward outputs not isolated");
    AST_FWD_ON: assert property (
        bp_data_oe |-> $past(fwd_drive_enable_n, 4) == 1'h0)
        else $error("forward data driven without enable");
    AST_REV_OFF: assert property (
        up_q > 4'h8 && $past(rev_drive_enable_n, 4)
        |-> !card_data_oe && !card_clock_return_oe)
        else $error("reverse outputs not isolated");
endmodule

bind bt_transceiver bt_checker bt_checker_inst (
    .clk, .reset, .card_data_in, .card_data_out, .card_data_oe,
    .bp_data_in, .bp_data_out, .bp_data_oe, .fwd_data_clock,
    .backplane_clock_line_in, .backplane_clock_line_out,
    .backplane_clock_line_oe, .card_clock_return_out,
    .card_clock_return_oe, .fwd_clk_enable_n, .fwd_latch_open,
    .rev_latch_open, .fwd_drive_enable_n, .rev_drive_enable_n
);

// ---- test/bt_transceiver_tb.sv ----
// Self-checking bench for the transceiver
`timescale 1ns/1ps
module bt_transceiver_tb;
    localparam int W = bt_pkg::WIDTH;
    typedef struct packed {
        logic [1:0]  k;
        logic [31:0] v;
    } bt_note_s;
    logic         clk, reset, hwrite, hready, hreadyout, hresp, drv_en;
    logic [W-1:0] card_data_in, card_data_out, bp_data_in, bp_data_out;
    logic [W-1:0] card_drv, drv_data, d0, dv [3];
    logic         card_data_oe, bp_data_oe, fwd_data_clock, rev_data_clock;
    logic         backplane_clock_line_in, backplane_clock_line_out;
    logic         backplane_clock_line_oe, card_clock_return_out;
    logic         card_clock_return_oe, fwd_clk_enable_n, rev_clk_enable_n;
    logic         fwd_latch_open, rev_latch_open;
    logic         fwd_drive_enable_n, rev_drive_enable_n;
    logic [1:0]   htrans;
    logic [31:0]  haddr, hwdata, hrdata, rd_v, hrdata_n;
    int           err_count, n_tests, cyc;
    bt_note_s     notes [$];
    event         smp;

    bt_transceiver bt_transceiver_inst (
        .clk, .reset, .card_data_in, .card_data_out, .card_data_oe,
        .bp_data_in, .bp_data_out, .bp_data_oe, .fwd_data_clock,
        .rev_data_clock, .backplane_clock_line_in, .backplane_clock_line_out,
        .backplane_clock_line_oe, .card_clock_return_out,
        .card_clock_return_oe, .fwd_clk_enable_n, .rev_clk_enable_n,
        .fwd_latch_open, .rev_latch_open, .fwd_drive_enable_n,
        .rev_drive_enable_n, .hsel(1'h1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata, .hresp
    );
    bt_bp_model bt_bp_model_inst (
        .clk, .reset, .dev_data(bp_data_out), .dev_data_oe(bp_data_oe),
        .dev_clk(backplane_clock_line_out),
        .dev_clk_oe(backplane_clock_line_oe), .drv_en, .drv_data,
        .bp_wire(bp_data_in), .clk_wire(backplane_clock_line_in)
    );
    // Card pins see the device when it drives, else the card logic
    assign card_data_in = card_data_oe ? card_data_out : card_drv;
    assign hready = hreadyout;

    // Clock and hang ceiling
    always #2 clk = !clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            finish_test();
        end
    end

    // Settled read data, so the data phase word is taken before its edge
    always @(negedge clk) hrdata_n = hrdata;

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Note an expected value; the monitor compares it at the negedge
    task automatic note(input logic [1:0] k, input logic [31:0] v);
        @(negedge clk);
        notes.push_back('{k, v});
        ->smp;
        @(posedge clk);
    endtask
    // One AHB-Lite single word transfer
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'h1);
        rd_v = hrdata_n;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'h0, a, 32'h0);
        note(2'h2, e);
    endtask
    // Comparisons of pin data and of bus words
    task automatic cmp_data(input logic [W-1:0] e, input logic [W-1:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // Monitor: oldest note against the settled output
    always @(smp) begin
        bt_note_s n;
        n = notes.pop_front();
        case (n.k)
            2'h0: cmp_data(n.v[W-1:0], bp_data_out);
            2'h1: cmp_data(n.v[W-1:0], card_data_out);
            2'h2: cmp_word(n.v, rd_v);
            default: cmp_word(n.v, {28'h0, card_data_oe, bp_data_oe,
                backplane_clock_line_oe, card_clock_return_oe});
        endcase
    end

    task automatic finish_test();
        $display("Checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {clk, haddr, hwrite, htrans, hwdata, cyc, err_count, n_tests} = '0;
        {card_drv, drv_data, drv_en, fwd_data_clock, rev_data_clock} = '0;
        {fwd_latch_open, rev_latch_open} = '0;
        {fwd_clk_enable_n, rev_clk_enable_n} = '1;
        {fwd_drive_enable_n, rev_drive_enable_n} = '1;
        reset = 1'h1;
        void'($urandom(32'h093B9D13));
        wt(3);
        reset <= 1'h0;
        note(2'h3, 32'h0);
        rd(bt_pkg::OFF_CTRL, 32'h0);
        rd(8'h20, 32'h0);
        ahb(1'h1, bt_pkg::OFF_CTRL, 32'h1);
        // Transparent forward, clock raised while enable blocks it
        d0 = W'($urandom);
        card_drv <= d0;
        fwd_drive_enable_n <= 1'h0;
        fwd_latch_open <= 1'h1;
        fwd_data_clock <= 1'h1;
        wt(10);
        note(2'h0, d0);
        note(2'h3, 32'h6);
        fwd_clk_enable_n <= 1'h0;
        wt(4);
        fwd_latch_open <= 1'h0;
        wt(6);
        card_drv <= ~d0;
        wt(10);
        note(2'h0, d0);
        fwd_data_clock <= 1'h0;
        wt(10);
        note(2'h0, d0);
        ahb(1'h0, bt_pkg::OFF_LOG, 32'h0);
        ahb(1'h0, bt_pkg::OFF_LOG, 32'h0);
        ahb(1'h1, bt_pkg::OFF_LOG_STAT, 32'h1);
        // Clocked captures: third one overflows the two-entry log
        for (int i = 0; i < 3; i++) begin
            dv[i] = W'($urandom);
            card_drv <= dv[i];
            wt(4);
            fwd_data_clock <= 1'h1;
            wt(6);
            note(2'h0, dv[i]);
            fwd_data_clock <= 1'h0;
            wt(4);
        end
        rd(bt_pkg::OFF_FWD_HELD, {15'h0, dv[2]});
        rd(bt_pkg::OFF_LOG_STAT, 32'h5);
        rd(bt_pkg::OFF_LOG, {1'h1, 13'h0, 1'h0, dv[0]});
        rd(bt_pkg::OFF_LOG, {1'h1, 13'h0, 1'h0, dv[1]});
        rd(bt_pkg::OFF_LOG, 32'h0);
        ahb(1'h1, bt_pkg::OFF_LOG_STAT, 32'h1);
        rd(bt_pkg::OFF_LOG_STAT, 32'h0);
        // Clock inhibit: edges ignored while enable is high
        fwd_clk_enable_n <= 1'h1;
        card_drv <= ~dv[2];
        repeat (4) begin
            wt(4);
            fwd_data_clock <= !fwd_data_clock;
        end
        wt(8);
        note(2'h0, dv[2]);
        fwd_drive_enable_n <= 1'h1;
        wt(8);
        note(2'h3, 32'h0);
        // Reverse direction, forward already isolated
        d0 = W'($urandom);
        drv_data <= d0;
        drv_en <= 1'h1;
        rev_drive_enable_n <= 1'h0;
        rev_latch_open <= 1'h1;
        wt(12);
        note(2'h1, d0);
        note(2'h3, 32'h9);
        rev_clk_enable_n <= 1'h0;
        rev_latch_open <= 1'h0;
        wt(6);
        drv_data <= ~d0;
        wt(4);
        rev_data_clock <= 1'h1;
        wt(8);
        note(2'h1, ~d0);
        wt(30);
        finish_test();
    end
endmodule
